// [rtl/lst_host.sv]
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "lst_host_regs.svh"
module lst_host #(
	parameter int unsigned TSEQ_SETS = `LST_TSEQ_SETS
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_n_in,
	input  wire lst_pkg::lst_apb_req_t apb_req_in,
	output logic [31:0]                apb_prdata_out,
	output logic                       apb_pready_out,
	output logic                       apb_pslverr_out,
	output lst_pkg::lst_sym_t          tx_sym_out,
	input  wire lst_pkg::lst_sym_t     rx_sym_in,
	input  wire logic                  rx_valid_in
);
	import lst_pkg::*;

	lst_host_st_t st_ff;
	lst_host_st_t nxt_st;
	lst_sym_t     tx_raw;
	lst_sym_t     tx_scr;
	lst_sym_t     rx_dscr;
	logic         tx_scr_en;
	logic         rx_scr_en;
	logic [15:0]  tx_lfsr;
	logic [15:0]  rx_lfsr;
	logic         rx_com;
	logic         rx_skp;
	logic [4:0]   rx_cur;
	logic [4:0]   rx_last;
	logic         rx_commit;
	logic         peer_scr_off;

	function automatic logic [7:0] lst_tseq_byte(input logic [4:0] idx);
		logic [7:0] b;
		b = `LST_D10_2;
		case (idx)
			5'd1:    b = 8'hFF;
			5'd2:    b = 8'h17;
			5'd3:    b = 8'hC0;
			5'd4:    b = 8'h14;
			5'd5:    b = 8'hB2;
			5'd6:    b = 8'hE7;
			5'd7:    b = 8'h02;
			5'd8:    b = 8'h82;
			5'd9:    b = 8'h72;
			5'd10:   b = 8'h6E;
			5'd11:   b = 8'h28;
			5'd12:   b = 8'hA6;
			5'd13:   b = 8'hBE;
			5'd14:   b = 8'h6D;
			5'd15:   b = 8'hBF;
			default: b = `LST_D10_2;
		endcase
		return b;
	endfunction : lst_tseq_byte

	function automatic logic [7:0] lst_fix_cfg(input logic [7:0] c);
		logic [7:0] f;
		f = c & `LST_LCFG_MASK;
		if (f[`LST_LCFG_RESET] && f[`LST_LCFG_LOOPBACK]) begin
			f[`LST_LCFG_LOOPBACK] = 1'b0;
		end
		return f;
	endfunction : lst_fix_cfg

	// Symbol chosen for this slot, before the scrambler
	always_comb begin
		tx_raw = '{k: 1'b0, data: `LST_D0_0};
		unique case (st_ff.tx_state)
			TX_IDLE: begin
				if (st_ff.pend_v) begin
					tx_raw = st_ff.pend;
				end
			end
			TX_TSEQ: begin
				if (st_ff.tx_idx == 5'd0) begin
					tx_raw = '{k: 1'b1, data: `LST_SYM_COM};
				end else begin
					tx_raw.data = lst_tseq_byte(st_ff.tx_idx);
				end
			end
			TX_TS1, TX_TS2: begin
				if (st_ff.tx_idx < `LST_TS_COMS) begin
					tx_raw = '{k: 1'b1, data: `LST_SYM_COM};
				end else if (st_ff.tx_idx == `LST_TS_RSV_IDX) begin
					tx_raw.data = `LST_D0_0;
				end else if (st_ff.tx_idx == `LST_TS_CFG_IDX) begin
					tx_raw.data = st_ff.lcfg;
				end else begin
					tx_raw.data = (st_ff.tx_state == TX_TS2) ? `LST_D5_2 : `LST_D10_2;
				end
			end
		endcase
	end

	// Training sets go out raw; only idle traffic is scrambled
	assign peer_scr_off = st_ff.rx_cfg_v && st_ff.rx_cfg[`LST_LCFG_SCRDIS];
	assign tx_scr_en = !st_ff.scr_dis && !peer_scr_off && (st_ff.tx_state == TX_IDLE);
	assign rx_com    = rx_valid_in && rx_sym_in.k && (rx_sym_in.data == `LST_SYM_COM);
	assign rx_skp    = rx_sym_in.k && (rx_sym_in.data == `LST_SYM_SKP);
	assign rx_scr_en = !st_ff.scr_dis && !peer_scr_off && !st_ff.rx_in_ts;
	assign rx_cur    = st_ff.rx_idx + 5'd1;
	assign rx_last   = (st_ff.rx_coms >= 3'd4) ? `LST_TS_LAST : `LST_TSEQ_LAST;
	assign rx_commit = rx_valid_in && !rx_sym_in.k && st_ff.rx_in_ts
		&& (rx_cur == `LST_TS_LAST) && (st_ff.rx_coms >= 3'd4);

	// Scrambler sits ahead of the encoder, descrambler after the decoder
	lst_scrambler u_tx_scr (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.sym_in     (tx_raw),
		.adv_in     (1'b1),
		.scr_en_in  (tx_scr_en),
		.reinit_in  (st_ff.brst),
		.sym_out    (tx_scr),
		.lfsr_out   (tx_lfsr)
	);

	lst_scrambler u_rx_scr (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.sym_in     (rx_sym_in),
		.adv_in     (rx_valid_in),
		.scr_en_in  (rx_scr_en),
		.reinit_in  (st_ff.brst),
		.sym_out    (rx_dscr),
		.lfsr_out   (rx_lfsr)
	);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.brst = 1'b0;
		// K flag rides with the byte so the encoder treats K and D alike
		nxt_st.tx_sym = tx_scr;

		// Transmit sequencer; no SKP is ever inserted while training
		if (st_ff.tx_state == TX_IDLE) begin
			nxt_st.pend_v = 1'b0;
		end else if (st_ff.tx_idx == ((st_ff.tx_state == TX_TSEQ) ? `LST_TSEQ_LAST
				: `LST_TS_LAST)) begin
			nxt_st.tx_idx = 5'd0;
			if (st_ff.sets_left <= LST_SET_W'(1)) begin
				nxt_st.tx_state = TX_IDLE;
			end else begin
				nxt_st.sets_left = LST_SET_W'(st_ff.sets_left - LST_SET_W'(1));
			end
		end else begin
			nxt_st.tx_idx = st_ff.tx_idx + 5'd1;
		end

		// APB slave, answer one cycle into the access phase
		nxt_st.pready  = 1'b0;
		nxt_st.pslverr = 1'b0;
		nxt_st.prdata  = 32'h0000_0000;
		if (apb_req_in.psel && apb_req_in.penable && !st_ff.pready) begin
			nxt_st.pready = 1'b1;
			unique case (apb_req_in.paddr)
				`LST_OFS_CTRL: begin
					nxt_st.prdata = {16'h0000, st_ff.lcfg, 3'b000, 1'b0, st_ff.loopback,
						st_ff.scr_dis, st_ff.tx_state};
					if (apb_req_in.pwrite) begin
						nxt_st.tx_state = lst_tx_state_t'(
							apb_req_in.pwdata[`LST_CTRL_MODE_MSB:`LST_CTRL_MODE_LSB]);
						nxt_st.tx_idx    = 5'd0;
						nxt_st.sets_left = st_ff.count;
						nxt_st.scr_dis   = apb_req_in.pwdata[`LST_CTRL_SCRDIS];
						nxt_st.loopback  = apb_req_in.pwdata[`LST_CTRL_LOOPBACK];
						// Reseed only counts while looped back
						nxt_st.brst = apb_req_in.pwdata[`LST_CTRL_BRST]
							&& apb_req_in.pwdata[`LST_CTRL_LOOPBACK];
						// Software alone decides the reset bit
						nxt_st.lcfg = lst_fix_cfg(
							apb_req_in.pwdata[`LST_CTRL_LCFG_MSB:`LST_CTRL_LCFG_LSB]);
					end
				end
				`LST_OFS_COUNT: begin
					nxt_st.prdata = {15'h0000, st_ff.count};
					if (apb_req_in.pwrite) begin
						nxt_st.count = apb_req_in.pwdata[LST_SET_W-1:0];
					end
				end
				`LST_OFS_TXDATA: begin
					nxt_st.prdata = {22'h000000, st_ff.pend_v, st_ff.pend};
					// One slot; a write stalls until the sequencer drains it
					if (apb_req_in.pwrite && st_ff.pend_v) begin
						nxt_st.pready = 1'b0;
					end else if (apb_req_in.pwrite) begin
						nxt_st.pend   = '{k: apb_req_in.pwdata[`LST_DATA_K],
							data: apb_req_in.pwdata[7:0]};
						nxt_st.pend_v = 1'b1;
					end
				end
				`LST_OFS_STATUS: begin
					nxt_st.prdata = {16'h0000, st_ff.rx_cfg, 2'b00, st_ff.rx_inv, st_ff.rx_ts2,
						st_ff.rx_sub_err, st_ff.rx_conflict, st_ff.rx_cfg_v,
						st_ff.tx_state != TX_IDLE};
					if (!apb_req_in.pwrite) begin
						nxt_st.rx_conflict = 1'b0;
						nxt_st.rx_sub_err  = 1'b0;
					end
				end
				`LST_OFS_RXDATA: begin
					nxt_st.prdata = {22'h000000, st_ff.rx_data_v, st_ff.rx_data};
					if (!apb_req_in.pwrite) begin
						nxt_st.rx_data_v = 1'b0;
					end
				end
				default: begin
					nxt_st.pslverr = 1'b1;
				end
			endcase
		end

		// Receive side; sets come after the clears so an event is never lost
		if (rx_com) begin
			nxt_st.rx_in_ts    = 1'b1;
			nxt_st.rx_last_com = 1'b1;
			nxt_st.rx_coms     = st_ff.rx_last_com
				? ((st_ff.rx_coms >= 3'd4) ? 3'd4 : st_ff.rx_coms + 3'd1) : 3'd1;
			nxt_st.rx_idx      = st_ff.rx_last_com ? rx_cur : 5'd0;
		end else if (rx_valid_in && !rx_skp) begin
			nxt_st.rx_last_com = 1'b0;
			if (st_ff.rx_in_ts) begin
				nxt_st.rx_idx = rx_cur;
				if (rx_cur == rx_last) begin
					nxt_st.rx_in_ts = 1'b0;
				end
				if (rx_cur == `LST_TS_CFG_IDX) begin
					nxt_st.rx_cand = rx_sym_in.data;
				end
				// Swapped lane turns D10.2 into D21.5; this flag only shows in STATUS, nothing flips on it
				if (rx_sym_in.data == `LST_D21_5 && ((st_ff.rx_coms >= 3'd4)
						? (rx_cur >= `LST_TS_ID_IDX) : (rx_cur > `LST_TSEQ_HDR_LAST))) begin
					nxt_st.rx_inv = 1'b1;
				end
				if (rx_cur == `LST_TS_ID_IDX) begin
					nxt_st.rx_cand_ts2 = rx_sym_in.data == `LST_D5_2;
					nxt_st.rx_id_ok = (rx_sym_in.data == `LST_D5_2)
						|| (rx_sym_in.data == `LST_D10_2);
				end else if (rx_cur > `LST_TS_ID_IDX) begin
					nxt_st.rx_id_ok = st_ff.rx_id_ok && (rx_sym_in.data
						== (st_ff.rx_cand_ts2 ? `LST_D5_2 : `LST_D10_2));
				end
				if (rx_commit && nxt_st.rx_id_ok) begin
					if (st_ff.rx_cand[`LST_LCFG_RESET] && st_ff.rx_cand[`LST_LCFG_LOOPBACK]) begin
						nxt_st.rx_conflict = 1'b1;
					end else begin
						nxt_st.rx_cfg   = st_ff.rx_cand;
						nxt_st.rx_cfg_v = 1'b1;
						nxt_st.rx_ts2   = st_ff.rx_cand_ts2;
					end
				end
			end else begin
				nxt_st.rx_data   = rx_dscr;
				nxt_st.rx_data_v = 1'b1;
				if (rx_sym_in.k && rx_sym_in.data == `LST_SYM_SUB) begin
					// Flag only; never retrains the link
					nxt_st.rx_sub_err = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff           <= '0;
			st_ff.tx_state  <= TX_IDLE;
			st_ff.count     <= LST_SET_W'(TSEQ_SETS);
			st_ff.tx_sym    <= '{k: 1'b0, data: `LST_D0_0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign apb_prdata_out  = st_ff.prdata;
	assign apb_pready_out  = st_ff.pready;
	assign apb_pslverr_out = st_ff.pslverr;
	assign tx_sym_out      = st_ff.tx_sym;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_ts_cfg_slot;
		(st_ff.tx_state == TX_TS1 || st_ff.tx_state == TX_TS2)
			&& st_ff.tx_idx == `LST_TS_CFG_IDX;
	endsequence

	sequence s_rx_conflict_end;
		rx_commit && nxt_st.rx_id_ok
			&& st_ff.rx_cand[`LST_LCFG_RESET] && st_ff.rx_cand[`LST_LCFG_LOOPBACK];
	endsequence

	a_ts_com_code: assert property (
		(st_ff.tx_state == TX_TS1 || st_ff.tx_state == TX_TS2) && st_ff.tx_idx < `LST_TS_COMS
		|=> tx_sym_out.k && tx_sym_out.data == `LST_SYM_COM)
		else $error("TS COM symbol wrong");

	a_ts_raw_ident: assert property (
		st_ff.tx_state == TX_TS1 && st_ff.tx_idx >= `LST_TS_ID_IDX
		|=> !tx_sym_out.k && tx_sym_out.data == `LST_D10_2)
		else $error("TS1 identifier scrambled or wrong");

	a_cfg_reserved: assert property (
		s_ts_cfg_slot |=> (tx_sym_out.data & ~`LST_LCFG_MASK) == 8'h00)
		else $error("Reserved config bit sent set");

	a_cfg_exclusive: assert property (
		s_ts_cfg_slot |=> !(tx_sym_out.data[`LST_LCFG_RESET]
			&& tx_sym_out.data[`LST_LCFG_LOOPBACK]))
		else $error("Reset and loopback sent together");

	a_brst_reseed: assert property (
		st_ff.brst |=> tx_lfsr == `LST_LFSR_SEED && rx_lfsr == `LST_LFSR_SEED)
		else $error("BRST did not reseed both LFSRs");

	a_rx_conflict_hold: assert property (
		s_rx_conflict_end |=> $stable(st_ff.rx_cfg) && st_ff.rx_conflict)
		else $error("Conflicting config was taken");

	a_tseq_no_skp: assert property (
		st_ff.tx_state == TX_TSEQ |=> !(tx_sym_out.k && tx_sym_out.data == `LST_SYM_SKP))
		else $error("SKP sent during TSEQ");

endmodule : lst_host

// [rtl/lst_host_regs.svh]
`ifndef LST_HOST_REGS_SVH
`define LST_HOST_REGS_SVH

// Register offsets, byte addresses on the APB side
`define LST_OFS_CTRL        12'h000
`define LST_OFS_COUNT       12'h004
`define LST_OFS_TXDATA      12'h008
`define LST_OFS_STATUS      12'h00C
`define LST_OFS_RXDATA      12'h010

// CTRL fields
`define LST_CTRL_MODE_LSB   0
`define LST_CTRL_MODE_MSB   1
`define LST_CTRL_SCRDIS     2
`define LST_CTRL_LOOPBACK   3
`define LST_CTRL_BRST       4
`define LST_CTRL_LCFG_LSB   8
`define LST_CTRL_LCFG_MSB   15

// STATUS fields
`define LST_STAT_BUSY       0
`define LST_STAT_CFG_VALID  1
`define LST_STAT_CONFLICT   2
`define LST_STAT_SUB_ERR    3
`define LST_STAT_RX_TS2     4
`define LST_STAT_CFG_LSB    8
`define LST_STAT_CFG_MSB    15

// TXDATA and RXDATA fields
`define LST_DATA_K          8
`define LST_DATA_VALID      9

// Link configuration byte
`define LST_LCFG_RESET      0
`define LST_LCFG_LOOPBACK   2
`define LST_LCFG_SCRDIS     3
`define LST_LCFG_MASK       8'h0D

// Scrambler
`define LST_LFSR_SEED       16'hFFFF
`define LST_KEY_FIRST       8'hFF

// Special symbols, byte values with the K flag set
`define LST_SYM_SKP         8'h3C
`define LST_SYM_SDP         8'h5C
`define LST_SYM_EDB         8'h7C
`define LST_SYM_SUB         8'h9C
`define LST_SYM_COM         8'hBC
`define LST_SYM_RSVD        8'hDC
`define LST_SYM_SHP         8'hFB
`define LST_SYM_END         8'hFD
`define LST_SYM_SLC         8'hFE
`define LST_SYM_EPF         8'hF7

// Data symbols used in training sets
`define LST_D10_2           8'h4A
`define LST_D5_2            8'h45
`define LST_D0_0            8'h00
`define LST_D21_5           8'hB5

// Ordered set layout, symbol indices; default TSEQ set count
`define LST_TS_COMS         5'd4
`define LST_TS_RSV_IDX      5'd4
`define LST_TS_CFG_IDX      5'd5
`define LST_TS_ID_IDX       5'd6
`define LST_TS_LAST         5'd15
`define LST_TSEQ_HDR_LAST   5'd15
`define LST_TSEQ_LAST       5'd31
`define LST_TSEQ_SETS       65536

`endif

// [rtl/lst_pkg.sv]
package lst_pkg;

	localparam int unsigned LST_SET_W = 17;

	typedef struct packed {
		logic       k;
		logic [7:0] data;
	} lst_sym_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lst_apb_req_t;

	typedef enum logic [1:0] {TX_IDLE, TX_TSEQ, TX_TS1, TX_TS2} lst_tx_state_t;

	typedef struct packed {
		logic [15:0] lfsr;
	} lst_scr_st_t;

	typedef struct packed {
		lst_tx_state_t          tx_state;
		logic [4:0]             tx_idx;
		logic [LST_SET_W-1:0]   sets_left;
		logic [LST_SET_W-1:0]   count;
		logic                   scr_dis;
		logic                   loopback;
		logic                   brst;
		logic [7:0]             lcfg;
		logic                   pend_v;
		lst_sym_t               pend;
		lst_sym_t               tx_sym;
		logic [4:0]             rx_idx;
		logic [2:0]             rx_coms;
		logic                   rx_last_com;
		logic                   rx_in_ts;
		logic [7:0]             rx_cand;
		logic                   rx_id_ok;
		logic                   rx_cand_ts2;
		logic [7:0]             rx_cfg;
		logic                   rx_cfg_v;
		logic                   rx_ts2;
		logic                   rx_conflict;
		logic                   rx_sub_err;
		logic                   rx_inv;
		lst_sym_t               rx_data;
		logic                   rx_data_v;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
	} lst_host_st_t;

endpackage : lst_pkg

// [rtl/lst_scrambler.sv]
`timescale 1ns/1ps
`include "lst_host_regs.svh"
module lst_scrambler (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire lst_pkg::lst_sym_t sym_in,
	input  wire logic              adv_in,
	input  wire logic              scr_en_in,
	input  wire logic              reinit_in,
	output lst_pkg::lst_sym_t      sym_out,
	output logic [15:0]            lfsr_out
);
	import lst_pkg::*;

	lst_scr_st_t st_ff;
	lst_scr_st_t nxt_st;
	logic [15:0] stage [0:8];
	logic [7:0]  key;
	logic        is_skp;
	logic        is_com;

	function automatic logic [15:0] lst_step(input logic [15:0] s);
		// Galois form of x^16 + x^5 + x^4 + x^3 + 1
		return {s[14:5], s[4] ^ s[15], s[3] ^ s[15], s[2] ^ s[15], s[1:0], s[15]};
	endfunction : lst_step

	assign stage[0] = st_ff.lfsr;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			// Bit gi takes D15 first, then the register shifts
			assign key[gi]      = stage[gi][15];
			assign stage[gi+1]  = lst_step(stage[gi]);
		end
	endgenerate

	assign is_skp   = sym_in.k && (sym_in.data == `LST_SYM_SKP);
	assign is_com   = sym_in.k && (sym_in.data == `LST_SYM_COM);
	assign lfsr_out = st_ff.lfsr;

	always_comb begin
		nxt_st = st_ff;
		if (reinit_in || (adv_in && is_com)) begin
			nxt_st.lfsr = `LST_LFSR_SEED;
		end else if (adv_in && !is_skp) begin
			nxt_st.lfsr = stage[8];
		end
		sym_out = sym_in;
		if (scr_en_in && !sym_in.k) begin
			sym_out.data = sym_in.data ^ key;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff.lfsr <= `LST_LFSR_SEED;
		end else begin
			st_ff <= nxt_st;
		end
	end

	a_com_reseed: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		adv_in && is_com |=> st_ff.lfsr == `LST_LFSR_SEED)
		else $error("LFSR not reseeded after COM");

	a_skp_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		adv_in && is_skp && !reinit_in |=> $stable(st_ff.lfsr))
		else $error("LFSR moved on SKP");

	a_lfsr_live: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		st_ff.lfsr != 16'h0000)
		else $error("LFSR reached all zero");

	a_first_key: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		scr_en_in && !sym_in.k && st_ff.lfsr == `LST_LFSR_SEED
		|-> sym_out.data == (sym_in.data ^ `LST_KEY_FIRST))
		else $error("First key byte after seed wrong");

endmodule : lst_scrambler

// [sim/lst_dev_model.sv]
`timescale 1ns/1ps
`include "lst_host_regs.svh"
module lst_dev_model (
	input  wire logic         clk_sys_in,
	output lst_pkg::lst_sym_t rx_sym_out,
	output logic              rx_valid_out
);
	import lst_pkg::*;
	logic [15:0] lfsr = `LST_LFSR_SEED;

	initial begin
		rx_sym_out   = '0;
		rx_valid_out = 1'b0;
	end

	function automatic logic [23:0] scr8(input logic [15:0] l, input logic [7:0] d);
		logic [7:0] o;
		for (int i = 0; i < 8; i++) begin
			o[i] = d[i] ^ l[15];
			l    = {l[14:0], 1'b0} ^ (l[15] ? 16'h0039 : 16'h0000);
		end
		return {l, o};
	endfunction : scr8

	// One symbol a cycle; the LFSR reseeds on COM and steps on every other symbol but SKP
	task automatic put(input logic kf, input logic [7:0] d, input logic scr);
		logic [23:0] r;
		r = scr8(lfsr, d);
		@(posedge clk_sys_in);
		rx_valid_out <= 1'b1;
		rx_sym_out   <= {kf, (scr && !kf) ? r[7:0] : d};
		if (kf && d == `LST_SYM_COM) lfsr = `LST_LFSR_SEED;
		else if (!(kf && d == `LST_SYM_SKP)) lfsr = r[23:8];
	endtask : put

	// Released lane shows the inverse, never a stale copy
	task automatic idle;
		@(posedge clk_sys_in);
		rx_valid_out <= 1'b0;
		rx_sym_out   <= ~rx_sym_out;
	endtask : idle

	task automatic send_ts(input logic [7:0] id, input logic [7:0] cfg);
		repeat (4) put(1'b1, `LST_SYM_COM, 1'b0);
		put(1'b0, `LST_D0_0, 1'b0);
		put(1'b0, cfg, 1'b0);
		repeat (10) put(1'b0, id, 1'b0);
		idle();
	endtask : send_ts

	task automatic send_data(input logic [7:0] d, input logic scr);
		put(1'b0, d, scr);
		idle();
	endtask : send_data

	// Decoder substitute for an invalid code group
	task automatic send_bad;
		put(1'b1, `LST_SYM_SUB, 1'b0);
		idle();
	endtask : send_bad
endmodule : lst_dev_model

// [sim/lst_host_tb_top.sv]
`timescale 1ns/1ps
`include "lst_host_regs.svh"
`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("MISMATCH %s exp %h got %h", nm, e, g); \
	end \
end
module lst_host_tb_top;
	import lst_pkg::*;
	localparam int unsigned SETS = 4;
	localparam lst_sym_t    COM  = {1'b1, `LST_SYM_COM};
	logic         clk_sys_in;
	logic         rst_n_in;
	lst_apb_req_t req;
	logic [31:0]  prdata;
	logic [31:0]  rd;
	logic         pready;
	logic         pslverr;
	logic         err;
	lst_sym_t     tx_sym;
	lst_sym_t     rx_sym;
	logic         rx_valid;
	int           n_mismatch = 0;
	int           tests_run  = 0;
	int           cyc        = 0;

	lst_host #(.TSEQ_SETS(SETS)) i_dut (
		.clk_sys_in      (clk_sys_in),
		.rst_n_in        (rst_n_in),
		.apb_req_in      (req),
		.apb_prdata_out  (prdata),
		.apb_pready_out  (pready),
		.apb_pslverr_out (pslverr),
		.tx_sym_out      (tx_sym),
		.rx_sym_in       (rx_sym),
		.rx_valid_in     (rx_valid)
	);

	lst_dev_model i_dev (
		.clk_sys_in   (clk_sys_in),
		.rx_sym_out   (rx_sym),
		.rx_valid_out (rx_valid)
	);

	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	// Whole run is a few hundred cycles; this leaves wide margin
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic conclude;
		$display("counts: compared %0d mismatched %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_sys_in);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge clk_sys_in);
		req.penable <= 1'b1;
		// Only the bench timeout ends a stalled access
		do begin
			@(posedge clk_sys_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req <= '0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
			input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd & m)
	endtask : rdchk

	task automatic wait_tx(input lst_sym_t s, input string nm);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (tx_sym !== s && n < 100);
		`CHK(nm, s, tx_sym)
	endtask : wait_tx

	task automatic nxt(input lst_sym_t e, input string nm);
		@(posedge clk_sys_in);
		`CHK(nm, e, tx_sym)
	endtask : nxt

	task automatic t_reset;
		rdchk(`LST_OFS_COUNT, 32'h1FFFF, SETS, "count reset");
		rdchk(`LST_OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
		rdchk(`LST_OFS_STATUS, 32'hFFFFFFFF, 32'h0, "status reset");
		apb(1'b0, 12'h020, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		$display("test reset done");
	endtask : t_reset

	task automatic t_tseq;
		logic [7:0] hdr [15] = '{8'hFF, 8'h17, 8'hC0, 8'h14, 8'hB2, 8'hE7, 8'h02, 8'h82,
			8'h72, 8'h6E, 8'h28, 8'hA6, 8'hBE, 8'h6D, 8'hBF};
		wr(`LST_OFS_COUNT, 32'h1);
		wr(`LST_OFS_CTRL, 32'h1);
		wait_tx(COM, "tseq com");
		foreach (hdr[i]) nxt({1'b0, hdr[i]}, "tseq hdr");
		repeat (16) nxt({1'b0, `LST_D10_2}, "tseq tail");
		$display("test tseq done");
	endtask : t_tseq

	// Idle after the run is checked only when the expected config byte ce is zero
	task automatic t_ts(input logic [1:0] md, input logic [7:0] cw, input logic [7:0] ce,
			input logic [7:0] id, input int sets);
		logic [15:0] l;
		logic [23:0] r;
		wr(`LST_OFS_COUNT, sets);
		wr(`LST_OFS_CTRL, {16'h0, cw, 6'h0, md});
		for (int s = 0; s < sets; s++) begin
			wait_tx(COM, "ts com");
			repeat (3) nxt(COM, "ts com");
			nxt({1'b0, `LST_D0_0}, "ts rsvd");
			nxt({1'b0, ce}, "ts cfg");
			repeat (10) nxt({1'b0, id}, "ts id");
		end
		if (ce == 8'h00) begin
			l = `LST_LFSR_SEED;
			repeat (12) begin
				r = i_dev.scr8(l, 8'h00);
				l = r[23:8];
			end
			repeat (3) begin
				r = i_dev.scr8(l, 8'h00);
				l = r[23:8];
				nxt({1'b0, r[7:0]}, "idle scr");
			end
		end
		$display("test ts done");
	endtask : t_ts

	task automatic t_txdata;
		wr(`LST_OFS_CTRL, 32'h0);
		wr(`LST_OFS_TXDATA, {23'h0, 1'b1, `LST_SYM_SHP});
		wait_tx({1'b1, `LST_SYM_SHP}, "k raw");
		wr(`LST_OFS_CTRL, 32'h4);
		wr(`LST_OFS_TXDATA, 32'h5A);
		wait_tx({1'b0, 8'h5A}, "data raw");
		repeat (3) nxt({1'b0, 8'h00}, "idle raw");
		wr(`LST_OFS_CTRL, 32'h18);
		@(posedge clk_sys_in);
		nxt({1'b0, `LST_KEY_FIRST}, "brst reseed");
		rdchk(`LST_OFS_CTRL, 32'h1F, 32'h08, "brst reads 0");
		wr(`LST_OFS_CTRL, 32'h0);
		$display("test txdata done");
	endtask : t_txdata

	task automatic t_rx;
		i_dev.send_ts(`LST_D10_2, 8'h00);
		rdchk(`LST_OFS_STATUS, 32'hFF1E, 32'h0002, "rx ts1 plain");
		i_dev.send_data(8'h3A, 1'b1);
		rdchk(`LST_OFS_RXDATA, 32'h3FF, 32'h23A, "rx descr");
		i_dev.send_ts(`LST_D10_2, 8'h08);
		rdchk(`LST_OFS_STATUS, 32'hFF1E, 32'h0802, "rx ts1 cfg");
		i_dev.send_data(8'h3A, 1'b0);
		rdchk(`LST_OFS_RXDATA, 32'h3FF, 32'h23A, "rx scr off");
		i_dev.send_bad();
		rdchk(`LST_OFS_STATUS, 32'hFF0E, 32'h080A, "rx sub");
		i_dev.send_ts(`LST_D5_2, 8'h04);
		rdchk(`LST_OFS_STATUS, 32'hFF1E, 32'h0412, "rx ts2 lpbk");
		i_dev.send_ts(`LST_D10_2, 8'h05);
		rdchk(`LST_OFS_STATUS, 32'hFF06, 32'h0406, "rx conflict");
		i_dev.send_ts(`LST_D21_5, 8'h00);
		rdchk(`LST_OFS_STATUS, 32'h20, 32'h20, "rx polarity");
		$display("test rx done");
	endtask : t_rx

	initial begin
		rst_n_in = 1'b0;
		req      = '0;
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_tseq();
		t_ts(2'd2, 8'h00, 8'h00, `LST_D10_2, 2);
		t_ts(2'd3, 8'hFF, 8'h09, `LST_D5_2, 1);
		t_txdata();
		t_rx();
		conclude();
	end
endmodule : lst_host_tb_top
